/* File: shared/pwm_bank_pkg.sv */
package pwm_bank_pkg;

    // Register word width on the serial side
    localparam int unsigned WORD_W = 16;

    // Register selectors presented by the serial front end
    localparam logic [2:0] SEL_STATUS0 = 3'h0;
    localparam logic [2:0] SEL_CTRL5   = 3'h5;
    localparam logic [2:0] SEL_CTRL6   = 3'h6;
    localparam logic [2:0] SEL_CONFIG  = 3'h7;

    // Duty field layout, shared by both control words
    localparam int unsigned DUTY_W      = 7;
    localparam int unsigned DUTY_HI_LSB = 8;
    localparam int unsigned DUTY_LO_LSB = 0;

    // Single-bit field positions
    localparam int unsigned RATE_BIT   = 7;
    localparam int unsigned BRIDGE_BIT = 6;
    localparam int unsigned TW_BIT     = 3;
    localparam int unsigned OL_BIT     = 1;
    localparam int unsigned WD_BIT     = 0;

    // Status word zero layout
    localparam int unsigned OC_W   = 6;
    localparam int unsigned OC_LSB = 4;
    localparam int unsigned DS_W   = 4;
    localparam int unsigned DS_LSB = 0;

    // Reset values
    localparam logic [DUTY_W-1:0] DUTY_RST = 7'h00;
    localparam logic              BIT_RST  = 1'b0;
    localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;

    // Extract a duty field from a written word
    function automatic logic [DUTY_W-1:0] duty_field(input logic [WORD_W-1:0] word,
                                                     input int unsigned      lsb);
        duty_field = word[lsb +: DUTY_W];
    endfunction : duty_field

endpackage : pwm_bank_pkg

/* File: verilog/sticky_flag_bank.sv */
// Synchronised sticky event flags with set-over-clear priority
module sticky_flag_bank
#(
    parameter int unsigned WIDTH = 10
)
(
    input  wire logic             clk_sys,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] event_in,
    input  wire logic             clear,
    output logic      [WIDTH-1:0] flags
);
    import pwm_bank_pkg::*;

    // Refuse an empty bank
    if (WIDTH < 1)
    begin : g_bad_width
        $error("sticky_flag_bank needs WIDTH of at least one");
    end

    typedef struct packed {
        logic [WIDTH-1:0] sync_a;   // First stage, read only by second stage
        logic [WIDTH-1:0] sync_b;   // Second stage, safe to use
        logic [WIDTH-1:0] sticky;   // Held flags
    } flag_state_s;

    flag_state_s state;         // Registered state
    flag_state_s next_state;    // Next value

    ////////////////////////////////////////////////////////////////////////
    // Next state: an event in the clear cycle survives the clear
    always_comb
    begin
        next_state        = state;
        next_state.sync_a = event_in;
        next_state.sync_b = state.sync_a;
        next_state.sticky = (clear ? '0 : state.sticky) | state.sync_b;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign flags = state.sticky;

endmodule : sticky_flag_bank

/* File: verilog/pwm_config_status_bank.sv */
// Functional notes
// - Channel b duty in control five 14:8
// - Channel a duty in control five 6:0
// - Channel d duty in control six 14:8
// - Channel c duty in control six 6:0
// - Control five bit 7 selects 122/244 Hz
// - Bridge enabled only while config bit 6
// - Config bit 3 masks thermal warning globally
// - Config bit 1 masks open-load globally
// - Sticky overcurrent flags in status bits 9:4
// - Sticky drain monitor flags in bits 3:0
module pwm_config_status_bank
(
    input  wire logic                              clk_sys,
    input  wire logic                              arst_n,
    input  wire logic [2:0]                        reg_sel,
    input  wire logic                              reg_wr,
    input  wire logic                              reg_rd,
    input  wire logic [pwm_bank_pkg::WORD_W-1:0]   reg_wdata,
    output logic      [pwm_bank_pkg::WORD_W-1:0]   reg_rdata,
    input  wire logic [pwm_bank_pkg::OC_W-1:0]     overcurrent_event,
    input  wire logic [pwm_bank_pkg::DS_W-1:0]     drain_monitor_event,
    input  wire logic                              thermal_warning_in,
    input  wire logic                              open_load_in,
    output logic      [pwm_bank_pkg::DUTY_W-1:0]   duty_channel_a,
    output logic      [pwm_bank_pkg::DUTY_W-1:0]   duty_channel_b,
    output logic      [pwm_bank_pkg::DUTY_W-1:0]   duty_channel_c,
    output logic      [pwm_bank_pkg::DUTY_W-1:0]   duty_channel_d,
    output logic                                   base_rate_select,
    output logic                                   bridge_enable,
    output logic                                   thermal_warning_mask,
    output logic                                   open_load_mask,
    output logic                                   watchdog_bit,
    output logic                                   global_status
);
    import pwm_bank_pkg::*;

    localparam int unsigned FLAG_W = OC_W + DS_W;   // Status word zero flag count

    // Refuse a package layout that the read mux cannot place in one word
    // (fields overlapping each other or running past the top bit)
    if ((OC_LSB + OC_W > WORD_W) || (DS_LSB + DS_W > OC_LSB)
        || (DUTY_HI_LSB + DUTY_W > WORD_W) || (DUTY_LO_LSB + DUTY_W > RATE_BIT))
    begin : g_bad_layout
        $error("pwm_config_status_bank register layout does not fit the word");
    end

    ////////////////////////////////////////////////////////////////////////
    // Register map as the serial front end presents it:
    //   Selector 5: channel b duty 14:8, base rate 7, channel a duty 6:0
    //   Selector 6: channel d duty 14:8, channel c duty 6:0
    //   Selector 7: bridge enable 6, thermal mask 3, open-load mask 1, watchdog 0
    //   Selector 0: overcurrent flags 9:4, drain monitor flags 3:0
    // Bit 15 and every other unnamed bit read back zero. A read and a write in
    // one cycle see the old contents, so the host never reads its own write back
    // in that cycle; it needs one more access to confirm it.
    // All block state except the sticky flags sits in one record; next_state is its combinational copy.

    typedef struct packed {
        logic [DUTY_W-1:0] duty_a;      // Channel a duty
        logic [DUTY_W-1:0] duty_b;      // Channel b duty
        logic [DUTY_W-1:0] duty_c;      // Channel c duty
        logic [DUTY_W-1:0] duty_d;      // Channel d duty
        logic              rate;        // Base rate select
        logic              bridge;      // Bridge enable
        logic              tw_mask;     // Thermal warning mask
        logic              ol_mask;     // Open-load mask
        logic              wd;          // Watchdog bit
        logic [1:0]        tw_sync;     // Thermal warning synchroniser
        logic [1:0]        ol_sync;     // Open-load synchroniser
        logic [WORD_W-1:0] rdata;       // Read data register
        logic              global_flag; // Global status indication
    } bank_state_s;

    bank_state_s       state;       // Registered state
    bank_state_s       next_state;  // Next value
    // Flags live in the sub-bank because they need their own set/clear rule
    logic [FLAG_W-1:0] flags;       // Sticky status flags
    logic              status_clr;  // Read of status word zero clears it

    ////////////////////////////////////////////////////////////////////////
    // Read image of one control word: two duty fields, every other bit zero
    function automatic logic [WORD_W-1:0] duty_pair_word(input logic [DUTY_W-1:0] hi,
                                                         input logic [DUTY_W-1:0] lo);
        duty_pair_word                        = WORD_RST;
        duty_pair_word[DUTY_HI_LSB +: DUTY_W] = hi;
        duty_pair_word[DUTY_LO_LSB +: DUTY_W] = lo;
    endfunction : duty_pair_word

    ////////////////////////////////////////////////////////////////////////
    // Status flags: reading the word is the clear. Only the read strobe clears,
    // so a selector that wanders between accesses cannot lose a flag; the flag
    // bank synchronises the raw event levels itself.
    assign status_clr = reg_rd && (reg_sel == SEL_STATUS0);

    // Overcurrent flags sit above the drain monitor flags, as in the status word

    sticky_flag_bank
    #(
        .WIDTH (FLAG_W)
    )
    u_flags
    (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .event_in ({overcurrent_event, drain_monitor_event}),
        .clear    (status_clr),
        .flags    (flags)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state: writes, read mux, global indication
    always_comb
    begin
        next_state = state;

        // Analog warnings arrive unsynchronised
        // Only the second stage feeds the global mux; the first may be metastable
        next_state.tw_sync = {state.tw_sync[0], thermal_warning_in};
        next_state.ol_sync = {state.ol_sync[0], open_load_in};

        // Reserved bits are simply dropped; the host is expected to write zero
        // A write to a word takes every implemented field of it at once
        if (reg_wr)
        begin
            case (reg_sel)
                SEL_CTRL5:
                begin
                    next_state.duty_b = duty_field(reg_wdata, DUTY_HI_LSB);
                    next_state.duty_a = duty_field(reg_wdata, DUTY_LO_LSB);
                    next_state.rate   = reg_wdata[RATE_BIT];
                end
                SEL_CTRL6:
                begin
                    next_state.duty_d = duty_field(reg_wdata, DUTY_HI_LSB);
                    next_state.duty_c = duty_field(reg_wdata, DUTY_LO_LSB);
                end
                SEL_CONFIG:
                begin
                    next_state.bridge  = reg_wdata[BRIDGE_BIT];
                    next_state.tw_mask = reg_wdata[TW_BIT];
                    next_state.ol_mask = reg_wdata[OL_BIT];
                    next_state.wd      = reg_wdata[WD_BIT];
                end
                default:
                begin
                    // Status and unmapped selectors ignore writes
                end
            endcase
        end

        // Read data; reserved and unmapped bits read zero
        // Read data is registered and stands until the next read strobe
        if (reg_rd)
        begin
            next_state.rdata = WORD_RST;
            case (reg_sel)
                SEL_CTRL5:
                begin
                    // Rate bit sits between the two duty fields
                    next_state.rdata = duty_pair_word(state.duty_b, state.duty_a);
                    next_state.rdata[RATE_BIT] = state.rate;
                end
                SEL_CTRL6:
                begin
                    next_state.rdata = duty_pair_word(state.duty_d, state.duty_c);
                end
                SEL_CONFIG:
                begin
                    next_state.rdata[BRIDGE_BIT] = state.bridge;
                    next_state.rdata[TW_BIT]     = state.tw_mask;
                    next_state.rdata[OL_BIT]     = state.ol_mask;
                    next_state.rdata[WD_BIT]     = state.wd;
                end
                SEL_STATUS0:
                begin
                    next_state.rdata[OC_LSB +: OC_W] = flags[DS_W +: OC_W];
                    next_state.rdata[DS_LSB +: DS_W] = flags[DS_W-1:0];
                end
                default:
                begin
                    next_state.rdata = WORD_RST;
                end
            endcase
        end

        // Global indication: masked warnings never reach it
        // Sticky flags are never masked; the masks act only on the live warnings
        next_state.global_flag = (|flags)
                               | (state.tw_sync[1] & ~state.tw_mask)
                               | (state.ol_sync[1] & ~state.ol_mask);
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; all fields clear on reset
    // The asynchronous clear gives known outputs before the first clock edge
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register
    // No logic sits between a state bit and its pin, so outputs never glitch
    assign duty_channel_a       = state.duty_a;
    assign duty_channel_b       = state.duty_b;
    assign duty_channel_c       = state.duty_c;
    assign duty_channel_d       = state.duty_d;
    assign base_rate_select     = state.rate;
    assign bridge_enable        = state.bridge;
    assign thermal_warning_mask = state.tw_mask;
    assign open_load_mask       = state.ol_mask;
    assign watchdog_bit         = state.wd;
    assign reg_rdata            = state.rdata;
    assign global_status        = state.global_flag;

endmodule : pwm_config_status_bank

/* File: bench/pwm_bank_properties.sv */
// Watches the register port and the outputs that it drives
module pwm_bank_checker
(
    input wire logic        clk_sys,
    input wire logic        arst_n,
    input wire logic [2:0]  reg_sel,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic [5:0]  overcurrent_event,
    input wire logic [6:0]  duty_channel_a,
    input wire logic [6:0]  duty_channel_d,
    input wire logic        base_rate_select,
    input wire logic        bridge_enable,
    input wire logic        global_status
);
    timeunit 1ns;
    timeprecision 1ps;
    import pwm_bank_pkg::*;
    // One clock domain, so clock and reset are given once
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    // Write strobes per word
    wire w5 = reg_wr && reg_sel == SEL_CTRL5;
    wire w6 = reg_wr && reg_sel == SEL_CTRL6;
    wire wc = reg_wr && reg_sel == SEL_CONFIG;
    // Read strobes of the words that are checked on read
    wire r5 = reg_rd && !reg_wr && reg_sel == SEL_CTRL5;
    wire rs = reg_rd && reg_sel == SEL_STATUS0;
    // Event held long enough to pass the two-flop synchroniser
    sequence oc_burst;
        $rose(overcurrent_event[5]) ##1 overcurrent_event[5] [*2];
    endsequence
    // A control read returns the old duty and a zero reserved bit
    property ctrl_rd_p;
        r5 |=> reg_rdata[6:0] == $past(duty_channel_a) && !reg_rdata[15];
    endproperty
    a_duty_a_wr: assert property (w5 |=> duty_channel_a == $past(reg_wdata[6:0]))
        else $error("duty a not written");
    a_duty_d_wr: assert property (w6 |=> duty_channel_d == $past(reg_wdata[14:8]))
        else $error("duty d not written");
    a_rate_wr: assert property (w5 |=> base_rate_select == $past(reg_wdata[7]))
        else $error("rate select not written");
    a_bridge_wr: assert property (wc |=> bridge_enable == $past(reg_wdata[6]))
        else $error("bridge enable not written");
    a_bridge_hold: assert property (!wc |=> $stable(bridge_enable))
        else $error("bridge enable moved without a write");
    a_status_res_zero: assert property (rs |=> reg_rdata[15:10] == 6'h00)
        else $error("reserved status bits not zero");
    a_ctrl_rd_old: assert property (ctrl_rd_p)
        else $error("control read wrong");
    a_oc_global: assert property (oc_burst |-> ##[1:4] global_status)
        else $error("overcurrent not reported");
endmodule : pwm_bank_checker
bind pwm_config_status_bank pwm_bank_checker i_chk (.clk_sys(clk_sys), .arst_n(arst_n),
    .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .overcurrent_event(overcurrent_event),
    .duty_channel_a(duty_channel_a), .duty_channel_d(duty_channel_d),
    .base_rate_select(base_rate_select), .bridge_enable(bridge_enable),
    .global_status(global_status));

/* File: bench/host_serial_model.sv */
// Host side of the register port; strobes move only on falling edges
module host_serial_model
(
    input  wire logic        clk_sys,
    input  wire logic [15:0] reg_rdata,
    output logic      [2:0]  reg_sel,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic      [15:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import pwm_bank_pkg::*;
    // Idle port from time zero
    initial
    begin
        reg_sel   = 3'h0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 16'h0000;
    end
    // Writable bits of each word; the host never sets reserved ones
    function automatic logic [15:0] legal(input logic [2:0] sel);
        case (sel)
            SEL_CTRL5: legal = 16'h7fff;
            SEL_CTRL6: legal = 16'h7f7f;
            default:   legal = 16'h004b;
        endcase
    endfunction : legal
    // One write; returns a cycle after the strobe so effects have landed
    task automatic put(input logic [2:0] sel, input logic [15:0] data);
        @(negedge clk_sys);
        reg_sel   = sel;
        reg_wdata = data & legal(sel);
        reg_wr    = 1'b1;
        @(negedge clk_sys);
        reg_wr    = 1'b0;
        reg_wdata = ~reg_wdata; // Stale data must not look valid
        @(negedge clk_sys);
    endtask : put
    // One read; a status read is also the clearing action
    task automatic get(input logic [2:0] sel, output logic [15:0] data);
        @(negedge clk_sys);
        reg_sel = sel;
        reg_rd  = 1'b1;
        @(negedge clk_sys);
        reg_rd  = 1'b0;
        @(negedge clk_sys);
        data    = reg_rdata;
    endtask : get
endmodule : host_serial_model

/* File: bench/tb_pwm_config_status_bank.sv */
module tb_pwm_config_status_bank;
    timeunit 1ns;
    timeprecision 1ps;
    import pwm_bank_pkg::*;
    logic        clk_sys = 1'b0;
    logic        arst_n, reg_wr, reg_rd, thermal_warning_in, open_load_in;
    logic        base_rate_select, bridge_enable, global_status;
    logic        thermal_warning_mask, open_load_mask, watchdog_bit;
    logic [2:0]  reg_sel;
    logic [15:0] reg_wdata, reg_rdata, d, n;
    logic [5:0]  overcurrent_event;
    logic [3:0]  drain_monitor_event;
    logic [6:0]  duty_channel_a, duty_channel_b, duty_channel_c, duty_channel_d;
    int          n_mismatch, total_checks, cycles;
    localparam logic [15:0] pats [3] = '{16'hffff, 16'h2a55, 16'h55aa};
    // 50 MHz clock
    always #10 clk_sys = ~clk_sys;
    pwm_config_status_bank i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .reg_sel(reg_sel),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .overcurrent_event(overcurrent_event), .drain_monitor_event(drain_monitor_event),
        .thermal_warning_in(thermal_warning_in), .open_load_in(open_load_in),
        .duty_channel_a(duty_channel_a), .duty_channel_b(duty_channel_b),
        .duty_channel_c(duty_channel_c), .duty_channel_d(duty_channel_d),
        .base_rate_select(base_rate_select), .bridge_enable(bridge_enable),
        .thermal_warning_mask(thermal_warning_mask), .open_load_mask(open_load_mask),
        .watchdog_bit(watchdog_bit), .global_status(global_status));
    host_serial_model i_host (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_sel(reg_sel),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Duty words at boundary and alternating patterns
    task automatic t_duty();
        foreach (pats[k])
        begin
            n = ~pats[k];
            i_host.put(SEL_CTRL5, pats[k]);
            i_host.put(SEL_CTRL6, n);
            chk(duty_channel_b, pats[k][14:8]);
            chk(duty_channel_a, pats[k][6:0]);
            chk(base_rate_select, pats[k][7]);
            chk({duty_channel_d, 1'b0, duty_channel_c}, n & 16'h7f7f);
            i_host.get(SEL_CTRL5, d);
            chk(d, pats[k] & 16'h7fff);
        end
    endtask : t_duty
    // Bridge enable and the two global masks
    task automatic t_bridge_masks();
        i_host.put(SEL_CONFIG, 16'hffff);
        chk({bridge_enable, thermal_warning_mask, open_load_mask, watchdog_bit}, 16'h000f);
        for (int k = 0; k < 2; k++)
        begin
            i_host.put(SEL_CONFIG, k ? 16'h0002 : 16'h0008);
            chk(bridge_enable, 1'b0);
            {thermal_warning_in, open_load_in} = k ? 2'b01 : 2'b10;
            repeat (5) @(negedge clk_sys);
            chk(global_status, 1'b0);
            i_host.put(SEL_CONFIG, 16'h0000);
            repeat (2) @(negedge clk_sys);
            chk(global_status, 1'b1);
            {thermal_warning_in, open_load_in} = 2'b00;
        end
    endtask : t_bridge_masks
    // Every status flag: set, held, read, cleared
    task automatic t_status();
        for (int i = 0; i < 10; i++)
        begin
            {overcurrent_event, drain_monitor_event} = 10'h001 << i;
            repeat (4) @(negedge clk_sys);
            {overcurrent_event, drain_monitor_event} = 10'h000;
            repeat (4) @(negedge clk_sys);
            chk(global_status, 1'b1);
            i_host.get(SEL_STATUS0, d);
            chk(d, 16'h0001 << i);
            i_host.get(SEL_STATUS0, d);
            chk(d, 16'h0000);
        end
        // An event still high at the clearing read keeps its flag set
        overcurrent_event = 6'h01;
        repeat (4) @(negedge clk_sys);
        i_host.get(SEL_STATUS0, d);
        chk(d, 16'h0010);
        i_host.get(SEL_STATUS0, d);
        chk(d, 16'h0010);
        overcurrent_event = 6'h00;
        repeat (4) @(negedge clk_sys);
        i_host.get(SEL_STATUS0, d);
        chk(d, 16'h0010);
        i_host.get(SEL_STATUS0, d);
        chk(d, 16'h0000);
    endtask : t_status
    ////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done
    // Hang guard, far above the few hundred cycles needed
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            test_done();
        end
    end
    initial
    begin
        arst_n = 1'b0;
        {overcurrent_event, drain_monitor_event, thermal_warning_in, open_load_in} = 12'h000;
        repeat (5) @(negedge clk_sys);
        arst_n = 1'b1;
        i_host.get(SEL_CONFIG, d);
        chk(d, 16'h0000);
        chk({duty_channel_a, duty_channel_d, base_rate_select, bridge_enable}, 16'h0000);
        chk({duty_channel_b, duty_channel_c}, 16'h0000);
        chk({watchdog_bit, thermal_warning_mask, open_load_mask}, 16'h0000);
        t_duty();
        t_bridge_masks();
        t_status();
        test_done();
    end
endmodule : tb_pwm_config_status_bank
